// ### efs_consts.vh
/*
 Constants of the directional residual-current stage: register map, field
 codes, timing and limits. Assumes inclusion by efs_stage.v only.
*/
`ifndef EFS_CONSTS_VH
`define EFS_CONSTS_VH
`define EFS_NUM        4
`define EFS_SETS       8
// Register offsets in units of 16 bytes, compared with PADDR[7:4], then the control reset value
`define EFS_A_CTRL     4'h0
`define EFS_A_STAT     4'h1
`define EFS_A_CNT_ST   4'h2
`define EFS_A_CNT_OP   4'h3
`define EFS_A_CNT_IN   4'h4
`define EFS_A_PREF     4'h5
`define EFS_A_STAMP    4'h6
`define EFS_CTRL_RST   11'h005
// Control fields
`define EFS_SEL_COARSE 2'h1
`define EFS_SEL_SENS   2'h2
`define EFS_SEL_CALC   2'h3
`define EFS_MAG_RMS    2'h1
`define EFS_MAG_HRM    2'h2
`define EFS_MAG_PP     2'h3
`define EFS_DLY_INST   2'h0
`define EFS_DLY_FIX    2'h1
`define EFS_DLY_INV    2'h2
// Forced status codes
`define EFS_F_START    3'h1
`define EFS_F_OPER     3'h2
`define EFS_F_INHIB    3'h3
// Nominal is 16'h1000; squelch 0.01 of nominal, rounded up
`define EFS_I_SQ       16'h0029
`define EFS_U_SQ       16'h0029
`define EFS_RST_PCT    24'h000061
`define EFS_PCT        24'h000064
// Timing
`define EFS_CLK_HZ     20000000
`define EFS_HZ_PER_KHZ 1000
`define EFS_STROBE_MS  32'h00000005
`define EFS_INV_MIN_MS 32'h00000014
`endif

// ### efs_stage.v
/*
 Four directional residual-current stages behind an APB slave.
 Assumes MEAS_STB pulses once per 5 ms with all magnitudes valid, and that
 the event buffer accepts one event in every cycle.
*/
// The implementer's own choices: the APB slave port and the register offsets.
`include "efs_consts.vh"
`default_nettype none
module efs_stage #(
  parameter MS_CYCLES = `EFS_CLK_HZ / `EFS_HZ_PER_KHZ
) (
  // Clock and reset
  input  wire        CORE_CLK,
  input  wire        ARST_N,
  // APB slave
  input  wire [11:0] PADDR,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // Measurements
  input  wire        MEAS_STB,
  input  wire [15:0] COARSE_RMS,
  input  wire [15:0] COARSE_HRM,
  input  wire [15:0] COARSE_PP,
  input  wire [15:0] SENS_RMS,
  input  wire [15:0] SENS_HRM,
  input  wire [15:0] SENS_PP,
  input  wire [15:0] CALC_I,
  input  wire [15:0] U0_MEAS,
  input  wire [15:0] U0_CALC,
  input  wire [7:0]  ANGLE,
  // Control inputs
  input  wire [3:0]  BLOCK,
  input  wire [2:0]  SET_SEL,
  // Stage outputs
  output wire [3:0]  START,
  output wire [3:0]  OPERATE,
  output wire [3:0]  INHIBIT,
  // Event buffer
  output wire        EVT_VALID,
  output wire [1:0]  EVT_INST,
  output wire [2:0]  EVT_CODE,
  output wire [31:0] EVT_STAMP
);

  function [15:0] selmag;
    input [1:0]  sel;
    input [1:0]  mode;
    input [15:0] c_r, c_h, c_p, s_r, s_h, s_p, calc;
    reg   [15:0] r, h, p;
    begin
      r = (sel == `EFS_SEL_SENS) ? s_r : c_r;
      h = (sel == `EFS_SEL_SENS) ? s_h : c_h;
      p = (sel == `EFS_SEL_SENS) ? s_p : c_p;
      if (sel == `EFS_SEL_CALC)
        selmag = calc;
      else if (mode == `EFS_MAG_HRM)
        selmag = h;
      else if (mode == `EFS_MAG_PP)
        selmag = p;
      else
        selmag = r;
    end
  endfunction

  // Hysteresis keeps a pick-up from chattering around its setting
  function hyst;
    input        held;
    input [15:0] mag;
    input [15:0] set;
    reg   [23:0] rel;
    begin
      rel  = ({8'h00, set} * `EFS_RST_PCT) / `EFS_PCT;
      hyst = held ? ({8'h00, mag} >= rel) : (mag > set);
    end
  endfunction

  reg  [10:0]  ctrl [0:`EFS_NUM-1];
  reg  [15:0]  iset [0:`EFS_NUM*`EFS_SETS-1];
  reg  [15:0]  uset [0:`EFS_NUM*`EFS_SETS-1];
  reg  [15:0]  dly  [0:`EFS_NUM*`EFS_SETS-1];
  reg  [15:0]  win  [0:`EFS_NUM*`EFS_SETS-1];
  reg  [3:0]   st_q;
  reg  [3:0]   op_q;
  reg  [3:0]   in_q;
  reg  [3:0]   av_q;
  reg  [191:0] cnt_q;
  reg  [63:0]  pref_q;
  reg  [31:0]  stamp;
  reg  [15:0]  mscnt;
  reg  [31:0]  prdata;
  reg          pready;
  reg          pslverr;
  reg  [11:0]  prev;
  reg  [11:0]  pend;
  reg  [11:0]  pon;
  reg  [3:0]   ptr;
  reg  [31:0]  evt_ts;
  reg          evt_valid;
  reg  [1:0]   evt_inst;
  reg  [2:0]   evt_code;
  reg  [31:0]  evt_stamp;
  reg  [31:0]  next_rd;
  reg          next_err;
  wire [11:0]  outs = {in_q, op_q, st_q};
  wire [11:0]  chg  = outs ^ prev;
  wire [11:0]  clr  = pend[ptr] ? (12'h001 << ptr) : 12'h000;
  wire [1:0]   ri   = PADDR[3:2];
  wire [4:0]   si   = PADDR[7:3];
  wire         setw = PADDR[11:9] == 3'h0 && PADDR[8] && PADDR[1:0] == 2'h0;
  wire         regw = PADDR[11:8] == 4'h0;
  integer      k;

  assign PRDATA    = prdata;
  assign PREADY    = pready;
  assign PSLVERR   = pslverr;
  assign START     = st_q;
  assign OPERATE   = op_q;
  assign INHIBIT   = in_q;
  assign EVT_VALID = evt_valid;
  assign EVT_INST  = evt_inst;
  assign EVT_CODE  = evt_code;
  assign EVT_STAMP = evt_stamp;

  genvar g;
  generate
    for (g = 0; g < `EFS_NUM; g = g + 1) begin : stg
      reg          pk_i;
      reg          pk_u;
      reg  [31:0]  acc;
      reg  [31:0]  el;
      integer      j;
      reg  [15:0]  hist [0:7];
      wire [10:0]  cf   = ctrl[g];
      wire [15:0]  m    = selmag(cf[1:0], cf[3:2], COARSE_RMS, COARSE_HRM, COARSE_PP,
                                 SENS_RMS, SENS_HRM, SENS_PP, CALC_I);
      wire [15:0]  u    = cf[4] ? U0_CALC : U0_MEAS;
      wire [15:0]  is   = iset[g*`EFS_SETS+SET_SEL];
      wire [15:0]  us   = uset[g*`EFS_SETS+SET_SEL];
      wire [15:0]  dl   = dly[g*`EFS_SETS+SET_SEL];
      wire [15:0]  wn   = win[g*`EFS_SETS+SET_SEL];
      wire         pi   = hyst(pk_i, m, is);
      wire         pu   = hyst(pk_u, u, us);
      wire         av   = (m > `EFS_I_SQ) && (u > `EFS_U_SQ);
      wire         dir  = av && ($signed(ANGLE) >= $signed(wn[7:0]))
                            && ($signed(ANGLE) <= $signed(wn[15:8]));
      wire         st_n = pi & ~BLOCK[g];
      wire         in_n = pi & BLOCK[g];
      wire         arm  = st_n & pu & dir;
      wire         inv  = cf[6:5] == `EFS_DLY_INV;
      wire [31:0]  inc  = inv ? {16'h0000, m} * `EFS_STROBE_MS : `EFS_STROBE_MS;
      wire [31:0]  thr  = inv ? {16'h0000, dl} * {16'h0000, is} : {16'h0000, dl};
      wire [31:0]  el_n = el + `EFS_STROBE_MS;
      wire         tmo  = (acc + inc >= thr) && (!inv || el_n >= `EFS_INV_MIN_MS);
      wire         op_n = arm & ((cf[6:5] == `EFS_DLY_INST) | tmo);
      wire [2:0]   fc   = cf[10:8];
      wire         fst  = fc != 3'h0 && fc != `EFS_F_INHIB;
      wire         fop  = fc == `EFS_F_OPER || (fc > `EFS_F_INHIB && fc[0]);
      wire         nst  = cf[7] ? fst : st_n;
      wire         nop  = cf[7] ? fop : op_n;
      wire         nin  = cf[7] ? (fc == `EFS_F_INHIB) : in_n;
      wire [17:0]  psum = {2'h0, hist[3]} + {2'h0, hist[4]} + {2'h0, hist[5]} + {2'h0, hist[6]};
      always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          pk_i                 <= 1'b0;
          pk_u                 <= 1'b0;
          acc                  <= 32'h00000000;
          el                   <= 32'h00000000;
          st_q[g]              <= 1'b0;
          op_q[g]              <= 1'b0;
          in_q[g]              <= 1'b0;
          av_q[g]              <= 1'b0;
          cnt_q[g*48 +: 48]    <= 48'h000000000000;
          pref_q[g*16 +: 16]   <= 16'h0000;
          for (j = 0; j < 8; j = j + 1)
            hist[j] <= 16'h0000;
        end else if (MEAS_STB) begin
          pk_i    <= pi;
          pk_u    <= pu;
          // Clamp at the threshold so a dipping current cannot undo a reached trip
          acc     <= arm ? (tmo ? thr : acc + inc) : 32'h00000000;
          el      <= arm ? el_n : 32'h00000000;
          st_q[g] <= nst;
          op_q[g] <= nop;
          in_q[g] <= nin;
          av_q[g] <= av;
          hist[0] <= m;
          for (j = 1; j < 8; j = j + 1)
            hist[j] <= hist[j-1];
          // Samples 20 to 35 ms old span the 20 ms ending 20 ms before now
          if ((nst & ~st_q[g]) | (nop & ~op_q[g]))
            pref_q[g*16 +: 16] <= psum[17:2];
          if (nst & ~st_q[g])
            cnt_q[g*48 +: 16] <= cnt_q[g*48 +: 16] + 16'h0001;
          if (nop & ~op_q[g])
            cnt_q[g*48+16 +: 16] <= cnt_q[g*48+16 +: 16] + 16'h0001;
          if (nin & ~in_q[g])
            cnt_q[g*48+32 +: 16] <= cnt_q[g*48+32 +: 16] + 16'h0001;
        end
      end
    end
  endgenerate

  // Millisecond time base
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mscnt <= 16'h0000;
      stamp <= 32'h00000000;
    end else if (mscnt == MS_CYCLES - 1) begin
      mscnt <= 16'h0000;
      stamp <= stamp + 32'h00000001;
    end else begin
      mscnt <= mscnt + 16'h0001;
    end
  end

  // Events: every change of one strobe shares the stamp latched at that strobe
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prev      <= 12'h000;
      pend      <= 12'h000;
      pon       <= 12'h000;
      ptr       <= 4'h0;
      evt_ts    <= 32'h00000000;
      evt_valid <= 1'b0;
      evt_inst  <= 2'h0;
      evt_code  <= 3'h0;
      evt_stamp <= 32'h00000000;
    end else begin
      prev <= outs;
      if (MEAS_STB)
        evt_ts <= stamp;
      pend <= (pend & ~clr) | chg;
      pon  <= (pon & ~chg) | (outs & chg);
      ptr  <= (ptr == 4'hB) ? 4'h0 : ptr + 4'h1;
      evt_valid <= pend[ptr];
      evt_inst  <= ptr[1:0];
      evt_code  <= {pon[ptr], ptr[3:2]};
      evt_stamp <= evt_ts;
    end
  end

  // APB read decode
  always @* begin
    next_rd  = 32'h00000000;
    next_err = 1'b0;
    if (setw) begin
      next_rd = PADDR[2] ? {win[si], dly[si]} : {uset[si], iset[si]};
    end else if (regw && PADDR[1:0] == 2'h0) begin
      case (PADDR[7:4])
        `EFS_A_CTRL:   next_rd = {21'h000000, ctrl[ri]};
        `EFS_A_STAT:   next_rd = {28'h0000000, av_q[ri], in_q[ri], op_q[ri], st_q[ri]};
        `EFS_A_CNT_ST: next_rd = {16'h0000, cnt_q[ri*48 +: 16]};
        `EFS_A_CNT_OP: next_rd = {16'h0000, cnt_q[ri*48+16 +: 16]};
        `EFS_A_CNT_IN: next_rd = {16'h0000, cnt_q[ri*48+32 +: 16]};
        `EFS_A_PREF:   next_rd = {16'h0000, pref_q[ri*16 +: 16]};
        `EFS_A_STAMP:  next_rd = stamp;
        default:       next_err = 1'b1;
      endcase
    end else begin
      next_err = 1'b1;
    end
    if (PWRITE && !setw && !(regw && PADDR[7:4] == `EFS_A_CTRL))
      next_err = 1'b1;
  end

  // APB slave: one wait state, writes land on the completing edge
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      for (k = 0; k < `EFS_NUM; k = k + 1)
        ctrl[k] <= `EFS_CTRL_RST;
      for (k = 0; k < `EFS_NUM*`EFS_SETS; k = k + 1) begin
        iset[k] <= 16'h0000;
        uset[k] <= 16'h0000;
        dly[k]  <= 16'h0000;
        win[k]  <= 16'h0000;
      end
    end else begin
      pready  <= PSEL & PENABLE & ~pready;
      pslverr <= PSEL & PENABLE & ~pready & next_err;
      prdata  <= (PSEL & PENABLE & ~pready & ~PWRITE) ? next_rd : 32'h00000000;
      if (PSEL & PENABLE & pready & PWRITE & ~next_err) begin
        if (setw && !PADDR[2]) begin
          iset[si] <= PWDATA[15:0];
          uset[si] <= PWDATA[31:16];
        end else if (setw) begin
          dly[si] <= PWDATA[15:0];
          win[si] <= PWDATA[31:16];
        end else begin
          ctrl[ri] <= PWDATA[10:0];
        end
      end
    end
  end

endmodule // efs_stage
`default_nettype wire

// ### efs_stage_sva.sv
/* Checker bound into efs_stage: APB timing, output relations, events.
   Assumes strobes at least fourteen cycles apart. */
`default_nettype none
module efs_stage_sva (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] PRDATA,
  // Stage and events
  input wire logic        MEAS_STB,
  input wire logic [3:0]  START,
  input wire logic [3:0]  OPERATE,
  input wire logic [3:0]  INHIBIT,
  input wire logic        EVT_VALID,
  input wire logic [1:0]  EVT_INST,
  input wire logic [2:0]  EVT_CODE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  logic [11:0] outs;
  logic [3:0]  kind;
  assign outs = {INHIBIT, OPERATE, START};
  assign kind = EVT_CODE[1] ? INHIBIT : (EVT_CODE[0] ? OPERATE : START);
  sequence s_setup;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  sequence s_change;
    MEAS_STB ##1 outs != $past(outs);
  endsequence
  a_ready_wait: assert property (s_setup |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  a_out_hold: assert property (!MEAS_STB |=> $stable(outs))
    else $error("outputs moved without strobe");
  a_start_inhib: assert property ((START & INHIBIT) == 4'h0)
    else $error("start and inhibit together");
  a_oper_start: assert property ((OPERATE & ~START) == 4'h0)
    else $error("operate without start");
  a_evt_follow: assert property (s_change |-> ##[2:13] EVT_VALID)
    else $error("no event after output change");
  a_evt_match: assert property (EVT_VALID |-> EVT_CODE[1:0] != 2'h3 &&
    kind[EVT_INST] == EVT_CODE[2])
    else $error("event does not match output");
endmodule // efs_stage_sva
bind efs_stage efs_stage_sva u_sva (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .MEAS_STB(MEAS_STB),
  .START(START), .OPERATE(OPERATE), .INHIBIT(INHIBIT), .EVT_VALID(EVT_VALID),
  .EVT_INST(EVT_INST), .EVT_CODE(EVT_CODE)
);
`default_nettype wire

// ### efs_meas_model.sv
/* Measurement front end model: one strobe every STB_CYCLES.
   Assumes the bench sets levels between strobes. */
`default_nettype none
module efs_meas_model #(
  parameter int STB_CYCLES = 20
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Levels from the bench
  input  wire logic [15:0] i_co,
  input  wire logic [15:0] i_se,
  input  wire logic [15:0] u,
  input  wire logic [7:0]  ang,
  // Towards the stage
  output var logic         stb,
  output logic [15:0]      co,
  output logic [15:0]      se,
  output logic [15:0]      uo,
  output logic [7:0]       ao
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      stb <= 1'b0;
    end else begin
      cnt <= (cnt == STB_CYCLES - 1) ? 0 : cnt + 1;
      stb <= (cnt == STB_CYCLES - 1);
    end
  end
  // Values hold only at the strobe; flipping elsewhere exposes early sampling
  assign co = stb ? i_co : ~i_co;
  assign se = stb ? i_se : ~i_se;
  assign uo = stb ? u : ~u;
  assign ao = stb ? ang : ~ang;
endmodule // efs_meas_model
`default_nettype wire

// ### efs_stage_test.sv
/* Bench for efs_stage: registers over APB, random measurements against a
   behavioural model, forcing codes. Assumes the bound checker. */
`default_nettype none
module efs_stage_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MSC = 4;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, stb, erv, evv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rdv, evs;
  logic [15:0] ico, ise, uu, co, se, uo;
  logic [7:0]  ang, ao;
  logic [3:0]  blk, st, op, ih, es, eo, ei, ev;
  logic [2:0]  ssel;
  logic [15:0] lv[8] = '{16'h0020, 16'h0300, 16'h07D0, 16'h0900,
                         16'h0400, 16'h3000, 16'h0100, 16'h0400};
  int          err_count, n_tests, cst, fc, nev, nevs, cyc, tsx;
  int          pki[4] = '{default: 0}, pkv[4] = '{default: 0}, el[4] = '{default: 0};
  int          acc[4] = '{default: 0};
  efs_stage #(.MS_CYCLES(MSC)) DUT (.CORE_CLK(clk), .ARST_N(rst_n),
    .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MEAS_STB(stb), .COARSE_RMS(co), .COARSE_HRM(co), .COARSE_PP(co),
    .SENS_RMS(se), .SENS_HRM(se), .SENS_PP(se), .CALC_I(co), .U0_MEAS(uo),
    .U0_CALC(uo), .ANGLE(ao), .BLOCK(blk), .SET_SEL(ssel), .START(st),
    .OPERATE(op), .INHIBIT(ih), .EVT_VALID(evv), .EVT_INST(), .EVT_CODE(),
    .EVT_STAMP(evs));
  efs_meas_model #(.STB_CYCLES(5 * MSC)) u_meas (.clk(clk), .rst_n(rst_n),
    .i_co(ico), .i_se(ise), .u(uu), .ang(ang), .stb(stb), .co(co), .se(se),
    .uo(uo), .ao(ao));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int iset(input int s, input int v);
    return s == 0 ? (v ? 'h200 : 'h800) : (s == 1 ? 'h4000 : 'h10);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    if (n >= 20) err_count++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step();
    int iv, is, us, pi, pv, dr, arm, inc, th, tm;
    logic [11:0] old;
    old = {ei, eo, es};
    is = iset(ssel, 0);
    us = iset(ssel, 1);
    for (int k = 0; k < 4; k++) begin
      iv = k == 2 ? ise : ico;
      pi = pki[k] ? iv * 100 >= is * 97 : iv > is;
      pv = pkv[k] ? uu * 100 >= us * 97 : uu > us;
      ev[k] = iv > 'h29 && uu > 'h29;
      dr = ev[k] && $signed(ang) >= -16 && $signed(ang) <= 16;
      es[k] = pi && !blk[k];
      ei[k] = pi && blk[k];
      arm = es[k] && pv && dr;
      inc = k == 2 ? iv * 5 : 5;
      th = k == 2 ? 10 * is : 15;
      el[k] = arm ? el[k] + 5 : 0;
      tm = acc[k] + inc >= th && (k != 2 || el[k] >= 20);
      acc[k] = arm ? (tm ? th : acc[k] + inc) : 0;
      eo[k] = arm && (k == 0 || k == 3 || tm);
      pki[k] = pi;
      pkv[k] = pv;
    end
    if (fc >= 0) begin
      es[3] = fc != 0 && fc != 3;
      eo[3] = fc == 2 || fc == 5 || fc == 7;
      ei[3] = fc == 3;
    end
    cst += es[0] && !old[0];
    nev += $countones({ei, eo, es} ^ old);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #400000;
    err_count++;
    wrap_up();
  end
  // Events must carry the millisecond count latched at their strobe
  always @(posedge clk) begin
    if (stb)
      tsx <= cyc / MSC;
    if (rst_n)
      cyc <= cyc + 1;
    if (evv === 1'b1) begin
      nevs <= nevs + 1;
      chk(evs, tsx);
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, blk, ssel} = '0;
    {ico, ise, uu, ang, es, eo, ei, ev} = '0;
    seed = 32'hAD44743B;
    fc = -1;
    cst = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 12'h000, 0); chk(rdv, 32'h005);
    apb(0, 12'h080, 0); chk(erv, 1);
    apb(1, 12'h010, 1); chk(erv, 1);
    apb(1, 12'h004, 32'h025);
    apb(1, 12'h008, 32'h046);
    apb(0, 12'h004, 0); chk(rdv, 32'h025);
    for (int i = 0; i < 4; i++)
      for (int s = 0; s < 3; s++) begin
        apb(1, 12'h100 + 12'h040 * i + 12'h008 * s, {16'(iset(s, 1)), 16'(iset(s, 0))});
        apb(1, 12'h104 + 12'h040 * i + 12'h008 * s,
            {16'h10F0, (i == 1) ? 16'h000F : ((i == 2) ? 16'h000A : 16'h0000)});
      end
    for (int t = 0; t < 48; t++) begin
      if (t >= 40) begin
        apb(1, 12'h00C, 32'h085 | ((t - 40) << 8));
        fc = t - 40;
      end
      repeat (25) seed = lfsr(seed);
      @(posedge clk);
      ico <= lv[seed[2:0]];
      ise <= lv[seed[5:3]];
      uu <= lv[seed[8:6]];
      ang <= {{2{seed[14]}}, seed[14:9]};
      blk <= seed[18:15] & seed[22:19];
      ssel <= (seed[24:23] == 2'h3) ? 3'h0 : {1'b0, seed[24:23]};
      @(posedge clk iff stb);
      step();
      @(negedge clk);
      chk({ih, op, st}, {ei, eo, es});
    end
    apb(0, 12'h020, 0); chk(rdv, cst);
    apb(0, 12'h010, 0); chk(rdv[3:0], {ev[0], ei[0], eo[0], es[0]});
    // Let the event scanner drain before the next strobe arrives
    repeat (8) @(posedge clk);
    chk(nevs, nev);
    wrap_up();
  end
endmodule // efs_stage_test
`default_nettype wire
